// ===== tb_top.sv
// self-checking bench for the baud-rate generator
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ubg_pkg::*;
    logic        i_mclk = 1'b0, i_rst_n = 1'b0, ext_run = 1'b0;
    logic        i_wr = 1'b0, i_bit_wr = 1'b0, i_bit_val = 1'b0, i_rd = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [2:0]  i_bit_sel = 3'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic [7:0]  o_rdata;
    logic [2:0]  o_port_mode;
    logic        i_ext_clk, o_os_tick, o_baud_tick, o_tx_enable, o_rx_enable;
    logic        o_three_wire_enable, o_stop_mode, o_sel_invalid;
    int          num_errors = 0, compares = 0;

    ubg_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
        .i_wdata(i_wdata), .i_bit_wr(i_bit_wr), .i_bit_sel(i_bit_sel), .i_bit_val(i_bit_val),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk(i_ext_clk), .o_os_tick(o_os_tick),
        .o_baud_tick(o_baud_tick), .o_tx_enable(o_tx_enable), .o_rx_enable(o_rx_enable),
        .o_three_wire_enable(o_three_wire_enable), .o_stop_mode(o_stop_mode),
        .o_sel_invalid(o_sel_invalid), .o_port_mode(o_port_mode));
    // 500 kHz pin clock
    ubg_pin_clk_model #(.HALF_NS(1000)) far (.i_run(ext_run), .o_pin_clk(i_ext_clk));

    // 20 MHz system clock
    always #25 i_mclk = ~i_mclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // one-cycle strobes, driven 2 ns after the edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        #2 {i_addr, i_wdata, i_wr} = {a, d, 1'b1};
        @(posedge i_mclk);
        #2 i_wr = 1'b0;
    endtask : wr
    task automatic bwr(input logic [15:0] a, input logic [2:0] b, input logic v);
        @(posedge i_mclk);
        #2 {i_addr, i_bit_sel, i_bit_val, i_bit_wr} = {a, b, v, 1'b1};
        @(posedge i_mclk);
        #2 i_bit_wr = 1'b0;
    endtask : bwr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        #2 {i_addr, i_rd} = {a, 1'b1};
        @(posedge i_mclk);
        #2 i_rd = 1'b0;
        @(posedge i_mclk);
        #2 check(o_rdata, exp);
    endtask : rd

    // cycles between the 2nd and 3rd tick, skipping the restart period
    task automatic period(input bit baud, input int lo, input int hi);
        int n, k;
        n = 0;
        k = 0;
        while (k < 3 && n < 9000) begin
            @(negedge i_mclk);
            if (k == 2) n++;
            if ((baud ? o_baud_tick : o_os_tick) === 1'b1) k++;
        end
        check(n >= lo && n <= hi, 1);
    endtask : period
    task automatic no_ticks;
        int t;
        t = 0;
        // a tick already in the two-stage pipeline may still drain
        repeat (2) @(negedge i_mclk);
        repeat (700) begin
            @(negedge i_mclk);
            if (o_os_tick !== 1'b0 || o_baud_tick !== 1'b0) t++;
        end
        check(t, 0);
    endtask : no_ticks

    task automatic t_reset;
        rd(ASYNC_ADDR, 8'h00);
        rd(SERMODE_ADDR, 8'h00);
        rd(BAUDSEL_ADDR, 8'h00);
        check({o_stop_mode, o_port_mode}, 4'hF);
        no_ticks();
    endtask : t_reset
    task automatic t_select;
        wr(BAUDSEL_ADDR, 8'h5F);
        rd(BAUDSEL_ADDR, 8'h50);
        bwr(BAUDSEL_ADDR, 3'h7, 1'b1);
        rd(BAUDSEL_ADDR, 8'h50);
        rd(16'hFF71, 8'h00);
    endtask : t_select
    task automatic t_rates;
        wr(ASYNC_ADDR, 8'h80);
        check(o_tx_enable, 1);
        for (int c = 0; c < 8; c++) begin // n = 1 allowed: system clock is 20 MHz
            wr(BAUDSEL_ADDR, 8'(c << 4));
            period(0, 2 << c, 2 << c);
            period(1, 32 << c, 32 << c);
        end
    endtask : t_rates
    task automatic t_external;
        ext_run = 1'b1;
        wr(BAUDSEL_ADDR, 8'h80);
        check(o_port_mode, 3'b100);
        period(0, 39, 41);
        period(1, 639, 641);
        wr(BAUDSEL_ADDR, 8'h90);
        check(o_sel_invalid, 1);
        no_ticks();
        ext_run = 1'b0;
        wr(BAUDSEL_ADDR, 8'h10);
        check(o_sel_invalid, 0);
    endtask : t_external
    task automatic t_modes;
        bwr(ASYNC_ADDR, 3'h6, 1'b1);
        check({o_tx_enable, o_rx_enable}, 2'h3);
        period(1, 64, 64);
        wr(ASYNC_ADDR, 8'h00);
        bwr(SERMODE_ADDR, 3'h7, 1'b1);
        check({o_three_wire_enable, o_stop_mode}, 2'h2);
        rd(SERMODE_ADDR, 8'h80);
        bwr(SERMODE_ADDR, 3'h7, 1'b0);
        check({o_stop_mode, o_port_mode}, 4'hF);
        no_ticks();
    endtask : t_modes

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    // run is about 30k cycles; watchdog allows 80k
    initial begin
        #4000000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge i_mclk);
        #2 i_rst_n = 1'b1;
        t_reset();
        t_select();
        t_rates();
        t_external();
        t_modes();
        stop_test();
    end
endmodule : tb_top

// ===== ubg_clk_if.sv
// carrier between the register side and the prescaler
interface ubg_clk_if;
    logic [3:0] sel;
    logic       run;
    logic       restart;
    logic       src_tick;
    modport src  (input sel, input run, input restart, output src_tick);
    modport sink (output sel, output run, output restart, input src_tick);
endinterface : ubg_clk_if

// ===== ubg_pin_clk_model.sv
// far-side station model: drives the external baud clock pin
module ubg_pin_clk_model #(
    parameter int HALF_NS = 1000
) (
    // run request from the bench
    input  wire logic i_run,
    // clock toward the pin, which software keeps as an input
    output logic      o_pin_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    initial o_pin_clk = 1'b0;
    // clock stands still low outside use, so no stray edge is counted
    always begin
        wait (i_run);
        #(HALF_NS) o_pin_clk = i_run ? ~o_pin_clk : 1'b0;
    end
endmodule : ubg_pin_clk_model

// ===== ubg_pkg.sv
// constants shared by the baud-rate generator and its prescaler
package ubg_pkg;
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 8;
    localparam int          GAP_W         = 13;
    // register addresses
    localparam logic [15:0] ASYNC_ADDR    = 16'hFF70;
    localparam logic [15:0] SERMODE_ADDR  = 16'hFF72;
    localparam logic [15:0] BAUDSEL_ADDR  = 16'hFF73;
    // reset values
    localparam logic [7:0]  ASYNC_RST     = 8'h00;
    localparam logic [7:0]  SERMODE_RST   = 8'h00;
    localparam logic [7:0]  BAUDSEL_RST   = 8'h00;
    // field positions and masks
    localparam int          TX_EN_BIT     = 7;
    localparam int          RX_EN_BIT     = 6;
    localparam int          THREE_WIRE_BIT = 7;
    localparam int          SRC_LSB       = 4;
    localparam logic [7:0]  BAUDSEL_MASK  = 8'hF0;
    // clock source codes
    localparam logic [3:0]  SRC_INT_MAX   = 4'h7;
    localparam logic [3:0]  SRC_EXT       = 4'h8;
    // oversampling: source ticks per bit time
    localparam logic [3:0]  OS_LAST       = 4'hF;
    localparam logic [7:0]  DIV_FULL_MASK = 8'hFF;
endpackage : ubg_pkg

// ===== ubg_prescaler.sv
// source clock prescaler: system clock by 2^n, or synchronised pin edges
module ubg_prescaler
    import ubg_pkg::*;
(
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    // external clock pin
    input  wire logic i_ext_clk,
    // control and tick
    ubg_clk_if.src    bus
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [2:0] sync;
        logic       tick;
    } ubg_pre_st_t;

    ubg_pre_st_t st;
    ubg_pre_st_t next_st;
    logic [7:0]  mask;
    logic        ext_edge;

    // sync[0] feeds only sync[1]; edge uses the settled stages
    assign ext_edge = st.sync[1] & ~st.sync[2];
    // mask of n low bits, n = code + 1
    assign mask     = DIV_FULL_MASK >> (3'd7 - bus.sel[2:0]);

    // next state
    always_comb begin
        next_st      = st;
        next_st.sync = {st.sync[1:0], i_ext_clk};
        if (bus.restart || !bus.run) begin
            next_st.cnt = 8'h00; // a select register write or operation stop clears the division chain
        end else begin
            next_st.cnt = st.cnt + 8'h01;
        end
        next_st.tick = bus.run && !bus.restart &&
            (((bus.sel <= SRC_INT_MAX) && ((st.cnt & mask) == mask))
             || ((bus.sel == SRC_EXT) && ext_edge));
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.src_tick = st.tick;

    ext_edge_tick_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (bus.sel == SRC_EXT && bus.run && !bus.restart && ext_edge) |=> bus.src_tick)
        else $error("pin edge did not give a source tick");

    int_div_tick_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (bus.sel <= SRC_INT_MAX && bus.run && !bus.restart && (st.cnt & mask) != mask)
        |=> !bus.src_tick)
        else $error("source tick outside the 2^n boundary");
endmodule : ubg_prescaler

// ===== ubg_top.sv
// serial port baud-rate generator with mode registers and pin steering
// Behaviour
// - the baud clock select register lives at FF73H, takes byte writes only and resets to 00H.
// - source codes 0000 to 0111 pick the system clock divided by 2^n with n = code + 1.
// - code 1000 picks pin clock pulses; any other code is prohibited and gives no clock.
// - with an internal source the bit rate is the system clock over 2^(n+1) then over 8.
// - with the pin clock the bit rate is the pin frequency over 16.
// - a 500 kHz pin clock yields 31.25 kbps for MIDI.
// - the serial mode register at FF72H resets to 00H, takes bit or byte writes, bit 7 = 3-wire.
// - the async mode register at FF70H resets to 00H, takes bit or byte writes, 7 = tx, 6 = rx.
// - with 3-wire, tx and rx enables all clear no transfer runs and the pins are ports.
// - in asynchronous mode transmit and receive run at once, sharing the bit clock.
module ubg_top
    import ubg_pkg::*;
(
    // clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst_n,
    // register access
    input  wire logic [ubg_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                      i_wr,
    input  wire logic [ubg_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                      i_bit_wr,
    input  wire logic [2:0]                i_bit_sel,
    input  wire logic                      i_bit_val,
    input  wire logic                      i_rd,
    output logic      [ubg_pkg::DATA_W-1:0] o_rdata,
    // external baud clock pin
    input  wire logic                      i_ext_clk,
    // clocks to the serial engines
    output logic                           o_os_tick,
    output logic                           o_baud_tick,
    // mode outputs
    output logic                           o_tx_enable,
    output logic                           o_rx_enable,
    output logic                           o_three_wire_enable,
    output logic                           o_stop_mode,
    output logic                           o_sel_invalid,
    output logic [2:0]                     o_port_mode
);
    typedef struct packed {
        logic [7:0] async_mode;
        logic [7:0] ser_mode;
        logic [7:0] baud_sel;
        logic [3:0] os_cnt;
        logic       os_tick;
        logic       baud_tick;
        logic [7:0] rdata;
    } ubg_st_t;

    ubg_st_t    st;
    ubg_st_t    next_st;
    ubg_clk_if  clk_bus ();
    logic       stop;
    logic       sel_wr;

    // operation stop when no serial function is enabled
    assign stop   = !st.ser_mode[THREE_WIRE_BIT] && !st.async_mode[TX_EN_BIT]
                    && !st.async_mode[RX_EN_BIT];
    assign sel_wr = i_wr && (i_addr == BAUDSEL_ADDR);

    // prescaler control
    assign clk_bus.sel     = st.baud_sel[7:SRC_LSB];
    assign clk_bus.run     = !stop;
    assign clk_bus.restart = sel_wr;

    ubg_prescaler u_pre (
        .i_mclk    (i_mclk),
        .i_rst_n   (i_rst_n),
        .i_ext_clk (i_ext_clk),
        .bus       (clk_bus.src)
    );

    // register writes, divide-by-16 and read data
    always_comb begin
        next_st = st;
        if (i_wr && i_addr == ASYNC_ADDR) begin
            next_st.async_mode = i_wdata;
        end else if (i_wr && i_addr == SERMODE_ADDR) begin
            next_st.ser_mode = i_wdata;
        end else if (sel_wr) begin
            next_st.baud_sel = i_wdata & BAUDSEL_MASK;
        end else if (i_bit_wr && i_addr == ASYNC_ADDR) begin
            next_st.async_mode[i_bit_sel] = i_bit_val;
        end else if (i_bit_wr && i_addr == SERMODE_ADDR) begin
            next_st.ser_mode[i_bit_sel] = i_bit_val;
        end
        // bit writes to the select register are dropped: byte access only
        // both sources are oversampled 16x, one shared clock for tx and rx
        if (stop || sel_wr) begin
            next_st.os_cnt = 4'h0;
        end else if (clk_bus.src_tick) begin
            next_st.os_cnt = st.os_cnt + 4'h1;
        end
        next_st.os_tick   = clk_bus.src_tick && !stop;
        next_st.baud_tick = clk_bus.src_tick && !stop && !sel_wr
                            && (st.os_cnt == OS_LAST);
        // unmapped addresses read as zero
        if (!i_rd) begin
            next_st.rdata = st.rdata;
        end else if (i_addr == ASYNC_ADDR) begin
            next_st.rdata = st.async_mode;
        end else if (i_addr == SERMODE_ADDR) begin
            next_st.rdata = st.ser_mode;
        end else if (i_addr == BAUDSEL_ADDR) begin
            next_st.rdata = st.baud_sel;
        end else begin
            next_st.rdata = 8'h00;
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st            <= '0;
            st.async_mode <= ASYNC_RST;
            st.ser_mode   <= SERMODE_RST;
            st.baud_sel   <= BAUDSEL_RST;
        end else begin
            st <= next_st;
        end
    end

    // outputs from registers; stop, invalid select and port modes decoded from them
    assign o_rdata             = st.rdata;
    assign o_os_tick           = st.os_tick;
    assign o_baud_tick         = st.baud_tick;
    assign o_tx_enable         = st.async_mode[TX_EN_BIT];
    assign o_rx_enable         = st.async_mode[RX_EN_BIT];
    assign o_three_wire_enable = st.ser_mode[THREE_WIRE_BIT];
    assign o_stop_mode         = stop;
    assign o_sel_invalid       = st.baud_sel[7:SRC_LSB] > SRC_EXT;
    // 1 = general port; pins go serial only with their function enabled
    assign o_port_mode[0]      = stop || !(st.ser_mode[THREE_WIRE_BIT]
                                 || st.baud_sel[7:SRC_LSB] == SRC_EXT);
    assign o_port_mode[1]      = stop || !(st.ser_mode[THREE_WIRE_BIT]
                                 || st.async_mode[TX_EN_BIT]);
    assign o_port_mode[2]      = stop || !(st.ser_mode[THREE_WIRE_BIT]
                                 || st.async_mode[RX_EN_BIT]);

    // helper: cycles between bit ticks, trusted only after a clean period
    logic [GAP_W-1:0] gap;
    logic             clean;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap   <= '0;
            clean <= 1'b0;
        end else begin
            gap   <= st.baud_tick ? '0 : gap + 13'd1;
            clean <= (stop || sel_wr) ? 1'b0 : (st.baud_tick ? 1'b1 : clean);
        end
    end

    int_rate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st.baud_tick && clean && st.baud_sel[7:SRC_LSB] <= SRC_INT_MAX)
        |-> gap == GAP_W'((32 << st.baud_sel[6:SRC_LSB]) - 1))
        else $error("internal bit period is not 2^(n+1)*8 cycles");

    sel_byte_wr_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        sel_wr |=> st.baud_sel == ($past(i_wdata) & BAUDSEL_MASK))
        else $error("select register did not take the byte write");

    sel_bit_ign_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_bit_wr && !i_wr && i_addr == BAUDSEL_ADDR) |=> $stable(st.baud_sel))
        else $error("bit write changed the select register");

    sel_low_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_rd && i_addr == BAUDSEL_ADDR) |=> o_rdata[3:0] == 4'h0)
        else $error("select register low nibble read non-zero");

    sermode_bit_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_bit_wr && !i_wr && i_addr == SERMODE_ADDR && i_bit_sel == 3'd7)
        |=> o_three_wire_enable == $past(i_bit_val))
        else $error("3-wire enable did not follow the bit write");

    async_byte_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_wr && i_addr == ASYNC_ADDR)
        |=> o_tx_enable == $past(i_wdata[7]) && o_rx_enable == $past(i_wdata[6]))
        else $error("tx or rx enable did not follow the byte write");

    stop_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        stop |=> !o_baud_tick && !o_os_tick)
        else $error("bit clock ran in operation stop");

    stop_ports_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        stop |-> o_port_mode == 3'b111)
        else $error("pins not handed to ports in operation stop");

    bad_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (st.baud_sel[7:SRC_LSB] > SRC_EXT)[*3] |-> !o_os_tick)
        else $error("prohibited source code produced a clock");

    ext_div16_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (o_baud_tick && clean && st.baud_sel[7:SRC_LSB] == SRC_EXT)
        |-> $past(st.os_cnt) == OS_LAST)
        else $error("pin clock bit tick not on the 16th source tick");
endmodule : ubg_top
